// ===== hw/cpd_pkg.sv
`default_nettype none
package cpd_pkg;
	// flags_register bit positions
	localparam int FL_V = 7;
	localparam int FL_H = 4;
	localparam int FL_I = 3;
	localparam int FL_N = 2;
	localparam int FL_Z = 1;
	localparam int FL_C = 0;
	// values after reset
	localparam logic [7:0] FLAGS_RST = 8'h08;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h00ff;
	localparam logic [15:0] PC_RST = 16'h0000;
	// page-zero high address byte
	localparam logic [7:0] PAGE0_HI = 8'h00;
	// opcodes and opcode low-nibble groups
	localparam logic [7:0] OP_PREFIX = 8'h9e;
	localparam logic [7:0] OP_BR_CC = 8'h24;
	localparam logic [7:0] OP_SP_ADJ = 8'ha7;
	localparam logic [7:0] OP_PTR_ADJ = 8'haf;
	localparam logic [7:0] OP_CMPBR_PI = 8'h71;
	localparam logic [7:0] OP_CMPBR_OPI = 8'h61;
	localparam logic [7:0] OP_COPY_PI = 8'h7e;
	localparam logic [3:0] OPL_ADC = 4'h9;
	localparam logic [3:0] OPL_ADD = 4'hb;
	localparam logic [3:0] OPL_SHL = 4'h8;
	localparam logic [3:0] OPL_SHR = 4'h7;
	// apb register byte offsets
	localparam logic [7:0] RA_CTRL = 8'h00;
	localparam logic [7:0] RA_STATUS = 8'h04;
	localparam logic [7:0] RA_FLAGS = 8'h08;
	localparam logic [7:0] RA_ACC = 8'h0c;
	localparam logic [7:0] RA_PTR = 8'h10;
	localparam logic [7:0] RA_SP = 8'h14;
	localparam logic [7:0] RA_PC = 8'h18;
	localparam int CTRL_RUN = 0;
	localparam int ST_ILLEGAL = 0;
	localparam int ST_BUSY = 1;
	typedef enum logic [3:0] {md_none, md_lit, md_page0, md_long, md_ptr,
		md_ptr_short, md_ptr_long, md_stack_short, md_stack_long,
		md_ptr_postinc, md_ptr_short_postinc, md_rel} cpd_mode_t;
	typedef enum logic [3:0] {op_adc, op_add, op_shl, op_shr, op_brcc,
		op_spadj, op_ptradj, op_cmpbr, op_copy, op_bad} cpd_op_t;
	typedef enum logic [1:0] {tg_acc, tg_x, tg_mem} cpd_tgt_t;
endpackage
`default_nettype wire

// ===== hw/cpd_alu.sv
`timescale 1ns/10ps
`default_nettype none
module cpd_alu
	import cpd_pkg::*;
(
	input wire cpd_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] m,
	input wire logic cin,
	output logic [7:0] r,
	output logic v,
	output logic h,
	output logic c
);
	logic [8:0] sum;

	// add family and shifts; negative and zero are taken from r by the caller
	always_comb
	begin
		sum = 9'h000;
		r = a;
		v = 1'b0;
		h = 1'b0;
		c = 1'b0;
		unique case (op)
			op_adc, op_add:
			begin
				sum = {1'b0, a} + {1'b0, m} + {8'h00, (op == op_adc) & cin};
				r = sum[7:0];
				c = sum[8]; // carry out of bit 7, see [RULE_02]
				h = (a[3] & m[3]) | (m[3] & ~r[3]) | (~r[3] & a[3]);
				v = (a[7] & m[7] & ~r[7]) | (~a[7] & ~m[7] & r[7]);
			end
			op_shl:
			begin
				r = {a[6:0], 1'b0}; // see [RULE_18]
				c = a[7];
				v = r[7] ^ c;
			end
			op_shr:
			begin
				r = {a[7], a[7:1]}; // sign kept, see [RULE_18]
				c = a[0];
				v = r[7] ^ c;
			end
			default:
			begin
				r = a;
			end
		endcase
	end
endmodule // cpd_alu
`default_nettype wire

// ===== hw/cpd_addr.sv
`timescale 1ns/10ps
`default_nettype none
module cpd_addr
	import cpd_pkg::*;
(
	input wire cpd_mode_t mode,
	input wire logic [7:0] byte1,
	input wire logic [7:0] byte2,
	input wire logic [15:0] ptr,
	input wire logic [15:0] sp,
	input wire logic [15:0] pc,
	output logic [15:0] ea,
	output logic [15:0] target
);
	logic [15:0] word12;
	logic [15:0] short_off;
	logic [7:0] rel;

	// first byte is the high half of any two-byte field, see [RULE_05]
	assign word12 = {byte1, byte2}; // see [RULE_06] see [RULE_07] see [RULE_04]
	// short offsets are zero-extended, see [RULE_08]
	assign short_off = {8'h00, byte1};
	// relative byte is the last operand byte of the instruction
	assign rel = (mode == md_ptr_short_postinc) ? byte2 : byte1;
	// sign-extended displacement from the next instruction, see [RULE_10]
	assign target = pc + {{8{rel[7]}}, rel};

	// 16-bit sums wrap in the 64 KB space, see [RULE_09]
	always_comb
	begin
		unique case (mode)
			md_page0: ea = {PAGE0_HI, byte1}; // see [RULE_03]
			md_long: ea = word12;
			md_ptr, md_ptr_postinc: ea = ptr;
			md_ptr_short, md_ptr_short_postinc: ea = ptr + short_off;
			md_ptr_long: ea = ptr + word12;
			md_stack_short: ea = sp + short_off; // see [RULE_17]
			md_stack_long: ea = sp + word12;
			default: ea = ptr;
		endcase
	end
endmodule // cpd_addr
`default_nettype wire

// ===== hw/cpd_core.sv
// Behaviour
// [RULE_01] flags hold overflow bit 7, half carry bit 4, mask bit 3
// [RULE_02] flags hold negative bit 2, zero bit 1, carry out of bit 7 at 0
// [RULE_03] page-zero address is operand byte with high byte zero
// [RULE_04] two-byte memory values are high byte first, low byte next
// [RULE_05] long address takes high byte first, then low byte
// [RULE_06] long offsets high byte first; short offset is the low byte
// [RULE_07] two-byte literal operands arrive high byte first
// [RULE_08] short pointer offsets are unsigned, zero-extended
// [RULE_09] long offsets wrap in 64 KB, signed or unsigned alike
// [RULE_10] branches add signed byte to address after the instruction
// [RULE_11] pointer post-increment mode only for compare-branch and copy
// [RULE_12] short-offset post-increment mode only for compare-branch
// [RULE_13] add and add-with-carry update five flags, 2 to 5 cycles
// [RULE_14] stack and pointer adjust add signed byte, 2 cycles, no flags
// [RULE_15] branch on carry clear, opcode 24, 3 cycles, no flags
// [RULE_16] post-increment bumps pointer only after operand fetch
// [RULE_17] stack short mode adds unsigned byte to stack pointer
// [RULE_18] shifts move outgoing bit to carry; overflow is N xor C
// [RULE_19] prefix byte is taken before any operand byte is fetched
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module cpd_core
	import cpd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata
);
	typedef enum logic [2:0] {st_idle, st_op, st_b1, st_b2, st_mem,
		st_pad} cpd_state_t;

	cpd_state_t state, next_state;
	logic run, illegal, pfx;
	logic [3:0] cnt;
	logic [7:0] opc, b1, b2, flags, acc;
	logic [15:0] ptr, sp, pc;
	logic [7:0] cur_opc, byte1, byte2, alu_a, alu_m, alu_r;
	cpd_op_t op;
	cpd_mode_t mode;
	cpd_tgt_t tgt;
	logic [1:0] nbytes;
	logic needmem, exec, fetch, pc_inc, taken, wr_mem, alu_v, alu_h, alu_c;
	logic pc_rd;
	logic [3:0] total;
	logic [15:0] ea, target;
	logic apb_wr, apb_set, core_idle, addr_ok;

	// opcode under decode: live in the opcode cycle, latched afterwards
	assign cur_opc = (state == st_op) ? mem_rdata : opc;
	assign byte1 = (state == st_b1) ? mem_rdata : b1;
	assign byte2 = (state == st_b2) ? mem_rdata : b2;

	// decode; post-increment forms exist only for the listed opcodes
	always_comb
	begin
		op = op_bad;
		mode = md_none;
		tgt = tg_acc;
		if (cur_opc == OP_BR_CC && !pfx)
		begin
			op = op_brcc;
			mode = md_rel;
		end
		else if ((cur_opc == OP_SP_ADJ || cur_opc == OP_PTR_ADJ) && !pfx)
		begin
			op = (cur_opc == OP_SP_ADJ) ? op_spadj : op_ptradj; // see [RULE_14]
			mode = md_lit;
		end
		else if (cur_opc == OP_CMPBR_PI && !pfx)
		begin
			op = op_cmpbr;
			mode = md_ptr_postinc; // see [RULE_11]
		end
		else if (cur_opc == OP_COPY_PI && !pfx)
		begin
			op = op_copy;
			mode = md_ptr_postinc; // see [RULE_11]
		end
		else if (cur_opc == OP_CMPBR_OPI && !pfx)
		begin
			op = op_cmpbr;
			mode = md_ptr_short_postinc; // see [RULE_12]
		end
		else if (cur_opc[3:0] == OPL_ADC || cur_opc[3:0] == OPL_ADD)
		begin
			op = (cur_opc[3:0] == OPL_ADC) ? op_adc : op_add;
			unique case ({pfx, cur_opc[7:4]})
				5'h0a: mode = md_lit;
				5'h0b: mode = md_page0;
				5'h0c: mode = md_long;
				5'h0d: mode = md_ptr_long;
				5'h0e: mode = md_ptr_short;
				5'h0f: mode = md_ptr;
				5'h1d: mode = md_stack_long;
				5'h1e: mode = md_stack_short;
				default: op = op_bad;
			endcase
		end
		else if (cur_opc[3:0] == OPL_SHL || cur_opc[3:0] == OPL_SHR)
		begin
			op = (cur_opc[3:0] == OPL_SHL) ? op_shl : op_shr;
			tgt = tg_mem;
			unique case ({pfx, cur_opc[7:4]})
				5'h03: mode = md_page0;
				5'h04: tgt = tg_acc;
				5'h05: tgt = tg_x;
				5'h06: mode = md_ptr_short;
				5'h07: mode = md_ptr;
				5'h16: mode = md_stack_short;
				default: op = op_bad;
			endcase
		end
	end

	// operand byte count and memory need per mode
	always_comb
	begin
		unique case (mode)
			md_lit, md_page0, md_ptr_short, md_stack_short, md_rel,
			md_ptr_postinc: nbytes = 2'd1;
			md_long, md_ptr_long, md_stack_long,
			md_ptr_short_postinc: nbytes = 2'd2;
			default: nbytes = 2'd0;
		endcase
		needmem = !(mode == md_none || mode == md_lit || mode == md_rel);
	end

	// documented bus cycles; zero means no stretching
	always_comb
	begin
		total = 4'd0;
		unique case (op)
			op_adc, op_add: // see [RULE_13]
				unique case (mode)
					md_lit: total = 4'd2;
					md_page0, md_ptr_short, md_ptr: total = 4'd3;
					md_long, md_ptr_long, md_stack_short: total = 4'd4;
					md_stack_long: total = 4'd5;
					default: total = 4'd0;
				endcase
			op_shl, op_shr:
				unique case (mode)
					md_none: total = 4'd1;
					md_page0, md_ptr_short: total = 4'd5;
					md_ptr: total = 4'd4;
					md_stack_short: total = 4'd6;
					default: total = 4'd0;
				endcase
			op_brcc: total = 4'd3; // see [RULE_15]
			op_spadj, op_ptradj: total = 4'd2; // see [RULE_14]
			default: total = 4'd0;
		endcase
	end

	cpd_addr u_addr (
		.mode(mode),
		.byte1(byte1),
		.byte2(byte2),
		.ptr(ptr),
		.sp(sp),
		.pc(pc),
		.ea(ea),
		.target(target)
	);

	// shifts work on their own target; adds on acc and operand
	assign alu_a = (tgt == tg_x) ? ptr[7:0] :
		((tgt == tg_mem) ? mem_rdata : acc);
	assign alu_m = (mode == md_lit) ? byte1 : mem_rdata;

	cpd_alu u_alu (
		.op(op),
		.a(alu_a),
		.m(alu_m),
		.cin(flags[FL_C]),
		.r(alu_r),
		.v(alu_v),
		.h(alu_h),
		.c(alu_c)
	);

	assign taken = (op == op_brcc) ? !flags[FL_C] : // see [RULE_15]
		((op == op_cmpbr) && (acc == mem_rdata));
	assign wr_mem = (tgt == tg_mem && (op == op_shl || op == op_shr))
		|| op == op_copy;

	// bus sequencing: one memory access per clock, read data next clock
	always_comb
	begin
		next_state = state;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_addr = pc;
		mem_wdata = 8'h00;
		exec = 1'b0;
		fetch = 1'b0;
		pc_rd = 1'b0;
		unique case (state)
			st_idle: fetch = run;
			st_op:
				if (mem_rdata == OP_PREFIX && !pfx)
				begin
					mem_rd = 1'b1; // see [RULE_19]
					pc_rd = 1'b1;
				end
				else if (nbytes != 2'd0)
				begin
					mem_rd = 1'b1;
					pc_rd = 1'b1;
					next_state = st_b1;
				end
				else if (needmem)
				begin
					mem_rd = 1'b1;
					mem_addr = ea;
					next_state = st_mem;
				end
				else
					exec = 1'b1;
			st_b1:
				if (nbytes == 2'd2)
				begin
					mem_rd = 1'b1;
					pc_rd = 1'b1;
					next_state = st_b2;
				end
				else if (needmem)
				begin
					mem_rd = 1'b1;
					mem_addr = ea;
					next_state = st_mem;
				end
				else
					exec = 1'b1;
			st_b2:
			begin
				mem_rd = 1'b1;
				mem_addr = ea;
				next_state = st_mem;
			end
			st_mem: exec = 1'b1;
			st_pad: fetch = (cnt >= total) || !run;
		endcase
		if (exec)
		begin
			if (wr_mem)
			begin
				mem_wr = 1'b1;
				mem_addr = (op == op_copy) ? {PAGE0_HI, b1} : ea;
				mem_wdata = (op == op_copy) ? mem_rdata : alu_r;
				next_state = st_pad;
			end
			else if (taken || cnt < total)
				next_state = st_pad; // branch needs the new pc first
			else
				fetch = 1'b1;
		end
		if (fetch)
		begin
			mem_rd = run;
			pc_rd = run;
			mem_addr = pc;
			next_state = run ? st_op : st_idle;
		end
	end
	// marked per read, not by address compare: an operand that happens to
	// sit at pc must not bump it
	assign pc_inc = pc_rd;

	// sequencer state, cycle count and prefix
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= st_idle;
			cnt <= 4'd0;
			pfx <= 1'b0;
			opc <= 8'h00;
			b1 <= 8'h00;
			b2 <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (fetch)
				cnt <= run ? 4'd1 : 4'd0;
			else if (cnt != 4'hf)
				cnt <= cnt + 4'd1;
			if (fetch)
				pfx <= 1'b0;
			else if (state == st_op && mem_rdata == OP_PREFIX && !pfx)
				pfx <= 1'b1;
			if (state == st_op)
				opc <= mem_rdata;
			if (state == st_b1)
				b1 <= mem_rdata;
			if (state == st_b2)
				b2 <= mem_rdata;
		end
	end

	assign core_idle = (state == st_idle) && !run;
	assign apb_wr = psel && penable && pwrite && addr_ok;
	assign apb_set = psel && !penable;

	// architectural registers; software may load them only while stopped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags <= FLAGS_RST;
			acc <= ACC_RST;
			ptr <= PTR_RST;
			sp <= SP_RST;
			pc <= PC_RST;
		end
		else if (apb_wr && core_idle)
		begin
			unique case (paddr)
				RA_FLAGS: flags <= pwdata[7:0];
				RA_ACC: acc <= pwdata[7:0];
				RA_PTR: ptr <= pwdata[15:0];
				RA_SP: sp <= pwdata[15:0];
				RA_PC: pc <= pwdata[15:0];
				default: acc <= acc;
			endcase
		end
		else
		begin
			if (exec && taken)
				pc <= target; // see [RULE_10]
			else if (pc_inc)
				pc <= pc + 16'h0001;
			if (exec)
				unique case (op)
					op_adc, op_add:
					begin
						acc <= alu_r; // see [RULE_13]
						flags[FL_V] <= alu_v; // see [RULE_01]
						flags[FL_H] <= alu_h;
						flags[FL_N] <= alu_r[7]; // see [RULE_02]
						flags[FL_Z] <= (alu_r == 8'h00);
						flags[FL_C] <= alu_c;
					end
					op_shl, op_shr:
					begin
						if (tgt == tg_acc)
							acc <= alu_r;
						if (tgt == tg_x)
							ptr[7:0] <= alu_r;
						flags[FL_V] <= alu_v; // see [RULE_18]
						flags[FL_N] <= alu_r[7];
						flags[FL_Z] <= (alu_r == 8'h00);
						flags[FL_C] <= alu_c;
					end
					op_spadj: sp <= sp + {{8{byte1[7]}}, byte1};
					op_ptradj: ptr <= ptr + {{8{byte1[7]}}, byte1};
					op_cmpbr, op_copy:
					begin
						// operand already read, see [RULE_16]
						ptr <= ptr + 16'h0001;
						if (op == op_copy)
						begin
							flags[FL_V] <= 1'b0;
							flags[FL_N] <= mem_rdata[7];
							flags[FL_Z] <= (mem_rdata == 8'h00);
						end
					end
					default: acc <= acc; // branch and illegal leave state
				endcase
		end
	end

	// control and sticky status; a new illegal opcode beats the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run <= 1'b0;
			illegal <= 1'b0;
		end
		else
		begin
			if (apb_wr && paddr == RA_CTRL)
				run <= pwdata[CTRL_RUN];
			if (exec && op == op_bad)
				illegal <= 1'b1;
			else if (apb_wr && paddr == RA_STATUS && pwdata[ST_ILLEGAL])
				illegal <= 1'b0;
		end
	end

	// apb: zero wait states, read data captured in the setup cycle
	always_comb
	begin
		unique case (paddr)
			RA_CTRL, RA_STATUS, RA_FLAGS, RA_ACC, RA_PTR, RA_SP,
			RA_PC: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (apb_set)
			unique case (paddr)
				RA_CTRL: prdata <= {31'h0, run};
				RA_STATUS: prdata <= {30'h0, state != st_idle, illegal};
				RA_FLAGS: prdata <= {24'h0, flags};
				RA_ACC: prdata <= {24'h0, acc};
				RA_PTR: prdata <= {16'h0, ptr};
				RA_SP: prdata <= {16'h0, sp};
				RA_PC: prdata <= {16'h0, pc};
				default: prdata <= 32'h0000_0000;
			endcase
	end

	// checks
	AST_PAGE0: assert property ( // see [RULE_03]
		@(posedge pclk) disable iff (!presetn)
		(state == st_b1 && mode == md_page0 && mem_rd)
		|-> mem_addr[15:8] == 8'h00) else $error("page zero high byte");
	AST_LONG_ORDER: assert property ( // see [RULE_05]
		@(posedge pclk) disable iff (!presetn)
		(state == st_b2 && mode == md_long)
		|-> mem_addr == {b1, mem_rdata}) else $error("long address order");
	AST_SHORT_OFF: assert property ( // see [RULE_08]
		@(posedge pclk) disable iff (!presetn)
		(state == st_b1 && mode == md_ptr_short && mem_rd)
		|-> mem_addr == ptr + {8'h00, mem_rdata}) else $error("short offset");
	AST_STACK_OFF: assert property ( // see [RULE_17]
		@(posedge pclk) disable iff (!presetn)
		(state == st_b1 && mode == md_stack_short && mem_rd)
		|-> mem_addr == sp + {8'h00, mem_rdata}) else $error("stack offset");
	AST_BRCC_FLAGS: assert property ( // see [RULE_15]
		@(posedge pclk) disable iff (!presetn)
		(exec && op == op_brcc) |=> flags == $past(flags))
		else $error("branch flags");
	AST_BRCC_TARGET: assert property ( // see [RULE_10]
		@(posedge pclk) disable iff (!presetn)
		(exec && op == op_brcc && !flags[FL_C])
		|=> pc == $past(pc) + {{8{$past(byte1[7])}}, $past(byte1)})
		else $error("branch target");
	AST_SPADJ: assert property ( // see [RULE_14]
		@(posedge pclk) disable iff (!presetn)
		(exec && op == op_spadj) |=> sp == $past(sp)
		+ {{8{$past(byte1[7])}}, $past(byte1)} && flags == $past(flags))
		else $error("stack adjust");
	AST_ADD_CYCLES: assert property ( // see [RULE_13]
		@(posedge pclk) disable iff (!presetn)
		(exec && (op == op_adc || op == op_add) && run)
		|-> ##[0:4] (fetch && cnt == total))
		else $error("add cycle count");
	AST_POSTINC: assert property ( // see [RULE_16]
		@(posedge pclk) disable iff (!presetn)
		(exec && op == op_cmpbr) |=> ptr == $past(ptr) + 16'h0001)
		else $error("post increment");
	AST_SHIFT_V: assert property ( // see [RULE_18]
		@(posedge pclk) disable iff (!presetn)
		(exec && (op == op_shl || op == op_shr))
		|=> flags[FL_V] == (flags[FL_N] ^ flags[FL_C]))
		else $error("shift overflow");
	AST_PREFIX: assert property ( // see [RULE_19]
		@(posedge pclk) disable iff (!presetn)
		(state == st_op && mem_rdata == OP_PREFIX && !pfx)
		|=> state == st_op && pfx) else $error("prefix decode");
	COV_ADC: cover property (@(posedge pclk) exec && op == op_adc);
	COV_BRCC: cover property (@(posedge pclk) exec && op == op_brcc && taken);
	COV_CMPBR: cover property (@(posedge pclk) exec && op == op_cmpbr);
	COV_STACK_LONG: cover property (@(posedge pclk)
		exec && mode == md_stack_long);
endmodule // cpd_core
`default_nettype wire

// ===== verif/cpd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpd_mem_model
(
	input wire logic pclk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	// the bench loads the program image while the core is idle
	task automatic poke(input logic [15:0] a, input logic [7:0] d);
		mem[a] = d;
	endtask
	initial
	begin
		mem_rdata = 8'h00;
	end
	// one-cycle read latency; without a read the bus toggles so that
	// stale data never passes for an answer
	always @(posedge pclk)
	begin
		if (mem_wr === 1'b1)
			mem[mem_addr] <= mem_wdata;
		if (mem_rd === 1'b1)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule // cpd_mem_model
`default_nettype wire

// ===== verif/cpu_operand_decode_arith_subset_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_operand_decode_arith_subset_tb
	import cpd_pkg::*;
;
	typedef struct packed {logic use_it; logic err; logic [31:0] val;} cpd_note_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] mem_addr;
	logic mem_rd, mem_wr;
	logic [7:0] mem_wdata, mem_rdata;
	cpd_note_t notes[$];
	cpd_note_t nt;
	int n_errors, checks, cyc, seed;
	int first_at [0:33];

	cpd_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	cpd_mem_model i_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic miss(input string s);
		n_errors++;
		$display("mismatch at %0t: %s", $time, s);
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		apb_xfer(1'b1, a, d, rd);
	endtask

	task automatic apb_rd(input logic [7:0] a, output logic [31:0] rd);
		notes.push_back('{1'b0, 1'b0, 32'h0});
		apb_xfer(1'b0, a, 32'h0, rd);
	endtask

	task automatic apb_chk(input logic [7:0] a, input logic [31:0] v,
		input logic e = 1'b0);
		logic [31:0] rd;
		notes.push_back('{1'b1, e, v});
		apb_xfer(1'b0, a, 32'h0, rd);
	endtask

	function automatic logic [15:0] add_f(input logic [7:0] a,
		input logic [7:0] m, input logic ci, input logic [7:0] f);
		logic [8:0] s;
		logic [4:0] hs;
		logic [7:0] nf;
		s = {1'b0, a} + {1'b0, m} + {8'h00, ci};
		hs = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, ci};
		nf = f;
		nf[FL_V] = (a[7] == m[7]) && (s[7] != a[7]);
		nf[FL_H] = hs[4];
		nf[FL_N] = s[7];
		nf[FL_Z] = (s[7:0] == 8'h00);
		nf[FL_C] = s[8];
		return {s[7:0], nf};
	endfunction

	function automatic logic [15:0] shf(input logic [7:0] a,
		input logic left, input logic [7:0] f);
		logic [7:0] r, nf;
		r = left ? {a[6:0], 1'b0} : {a[7], a[7:1]};
		nf = f;
		nf[FL_C] = left ? a[7] : a[0];
		nf[FL_N] = r[7];
		nf[FL_Z] = (r == 8'h00);
		nf[FL_V] = r[7] ^ nf[FL_C];
		return {r, nf};
	endfunction

	// scoreboard: oldest note against each completed read
	always @(posedge pclk)
	begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
			&& pwrite === 1'b0)
		begin
			if (notes.size() == 0)
				miss("read without a note");
			else
			begin
				nt = notes.pop_front();
				if (nt.use_it)
				begin
					checks++;
					if (prdata !== nt.val || pslverr !== nt.err)
						miss("read data or error flag");
				end
			end
		end
	end

	// first fetch cycle of each program byte, and the hang limit
	always @(posedge pclk)
	begin
		cyc++;
		if (mem_rd === 1'b1 && mem_addr < 16'h0022
			&& first_at[mem_addr[5:0]] < 0)
			first_at[mem_addr[5:0]] = cyc;
		if (cyc > 20000)
		begin
			miss("timeout");
			give_verdict();
		end
	end

	initial
	begin
		logic [31:0] rd;
		logic [7:0] a0, i1, i2, m3, m4, m5, m6, m7, m8, k1, k2, acc, fl;
		logic [15:0] ptr, sp;
		logic [7:0] prog [$];
		int tries;
		int st [13] = '{0, 2, 4, 6, 9, 11, 13, 16, 18, 21, 25, 26, 27};
		int cy [12] = '{2, 2, 3, 4, 2, 3, 4, 2, 4, 5, 1, 1};
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		seed = 32'h1d42;
		n_errors = 0;
		checks = 0;
		cyc = 0;
		for (int i = 0; i < 34; i++)
			first_at[i] = -1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb_chk(RA_FLAGS, {24'h0, FLAGS_RST});
		apb_chk(RA_ACC, {24'h0, ACC_RST});
		apb_chk(RA_PTR, {16'h0, PTR_RST});
		apb_chk(RA_SP, {16'h0, SP_RST});
		apb_chk(RA_PC, {16'h0, PC_RST});
		apb_chk(RA_STATUS, 32'h0);
		apb_chk(8'h1c, 32'h0, 1'b1);
		// random data; pointer bases kept clear of the program image
		a0 = 8'($random(seed));
		i1 = 8'($random(seed));
		i2 = 8'($random(seed));
		m3 = 8'($random(seed));
		m4 = 8'($random(seed));
		m5 = 8'($random(seed));
		m6 = 8'($random(seed));
		m7 = 8'($random(seed));
		m8 = 8'($random(seed));
		k1 = 8'h80 | 8'($random(seed) & 32'h1f);
		k2 = 8'h80 | 8'($random(seed) & 32'h3f);
		ptr = {{8{k1[7]}}, k1};
		sp = SP_RST + {{8{k2[7]}}, k2};
		for (int i = 0; i < 65536; i++)
			i_mem.poke(16'(i), 8'(i) ^ 8'(i >> 8) ^ 8'h5a);
		i_mem.poke(16'h00c0, m3);
		i_mem.poke(16'h4321, m4);
		i_mem.poke(ptr + 16'h00c0, m5);
		i_mem.poke(ptr + 16'h8000, m6);
		i_mem.poke(sp + 16'h00a0, m7);
		i_mem.poke(sp + 16'h3000, m8);
		prog = {8'hab, i1, 8'ha9, i2, 8'hbb, 8'hc0, 8'hc9, 8'h43, 8'h21,
			8'haf, k1, 8'heb, 8'hc0, 8'hdb, 8'h80, 8'h00, 8'ha7, k2,
			8'h9e, 8'heb, 8'ha0, 8'h9e, 8'hd9, 8'h30, 8'h00, 8'h48,
			8'h47, 8'h24, 8'h02, 8'hab, 8'h00, 8'h24, 8'hfe};
		foreach (prog[i])
			i_mem.poke(16'(i), prog[i]);
		apb_wr(RA_ACC, {24'h0, a0});
		apb_chk(RA_ACC, {24'h0, a0});
		apb_wr(RA_CTRL, 32'h1);
		// refused while the core runs
		apb_wr(RA_ACC, 32'h55);
		tries = 0;
		while (first_at[31] < 0 && tries < 400)
		begin
			@(posedge pclk);
			tries++;
		end
		apb_wr(RA_CTRL, 32'h0);
		tries = 0;
		rd = 32'h2;
		while (rd[ST_BUSY] !== 1'b0 && tries < 50)
		begin
			apb_rd(RA_STATUS, rd);
			tries++;
		end
		// reference result of the program
		acc = a0;
		fl = FLAGS_RST;
		{acc, fl} = add_f(acc, i1, 1'b0, fl);
		{acc, fl} = add_f(acc, i2, fl[FL_C], fl);
		{acc, fl} = add_f(acc, m3, 1'b0, fl);
		{acc, fl} = add_f(acc, m4, fl[FL_C], fl);
		{acc, fl} = add_f(acc, m5, 1'b0, fl);
		{acc, fl} = add_f(acc, m6, 1'b0, fl);
		{acc, fl} = add_f(acc, m7, 1'b0, fl);
		{acc, fl} = add_f(acc, m8, fl[FL_C], fl);
		{acc, fl} = shf(acc, 1'b1, fl);
		{acc, fl} = shf(acc, 1'b0, fl);
		if (fl[FL_C])
		begin
			checks++;
			if (first_at[29] - first_at[27] != 3) miss("branch cycles");
			{acc, fl} = add_f(acc, 8'h00, 1'b0, fl);
		end
		apb_chk(RA_ACC, {24'h0, acc});
		apb_chk(RA_FLAGS, {24'h0, fl});
		apb_chk(RA_PTR, {16'h0, ptr});
		apb_chk(RA_SP, {16'h0, sp});
		apb_chk(RA_PC, 32'h1f);
		apb_chk(RA_STATUS, 32'h0);
		for (int i = 0; i < 12; i++)
		begin
			checks++;
			if (first_at[st[i + 1]] - first_at[st[i]] != cy[i]) miss("cycles");
		end
		give_verdict();
	end
endmodule // cpu_operand_decode_arith_subset_tb
`default_nettype wire
